// ==== rtl/ctg_top.sv ====
// Top of the colour tile gain selector: picks a gain code per pixel read.
// How it works
// - Four gain registers, six-bit code in bits 5..0, bits 7..6 unused.
// - Gain factor is 0.88 plus 0.06 per code unit.
// - Every gain code resets to 000010, unity gain.
// - Tile bits 3..2 columns, 1..0 rows; 00 one, 01 two, 1x four.
// - Tile size resets to two rows by two columns, value 05h.
// - At most four row definitions and four column positions.
// - Row byte holds four two-bit selectors, one per column position.
// - Row one resets to 00,01,00,01; row two to 10,11,10,11.
// - Default gains serve green-red green, red, blue, blue-green green.
// - Selected gain follows the pixel currently being read.
// - Gain codes shadowed to frame start; tile and rows take effect at once.
`timescale 1ns/10ps
`default_nettype none
module ctg_top
  import ctg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Parallel byte register port: write strobe, address and data in, registered read data out
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Pixel stream in
  input wire logic frame_start_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [ctg_pkg::CTG_IDX_W-1:0] pix_row_i,
  input wire logic [ctg_pkg::CTG_IDX_W-1:0] pix_col_i,
  // Gain codes out, one per pixel
  output logic gain_valid_o,
  input wire logic gain_ready_i,
  output logic [ctg_pkg::CTG_GAIN_W-1:0] gain_code_o,
  output logic [7:0] gain_x100_o
);
  import ctg_pkg::*;

  // ==========================================================================
  // Registers
  logic [3:0][5:0] gain_live;
  logic [3:0] tile;
  logic [3:0][7:0] row_def;

  ctg_regs u_regs (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(reg_wr_i),
    .addr_i(reg_addr_i),
    .wdata_i(reg_wdata_i),
    .rdata_o(reg_rdata_o),
    .frame_start_i(frame_start_i),
    .gain_live_o(gain_live),
    .tile_o(tile),
    .row_def_o(row_def)
  );

  // ==========================================================================
  // Selection
  typedef struct packed {
    logic [5:0] code;
    logic [7:0] x100;
  } ctg_sel_s;

  logic [1:0] tile_row;
  logic [1:0] tile_col;
  logic [1:0] selector;
  logic [7:0] cur_row_def;
  ctg_sel_s sel;

  // Tile sizes are powers of two, so modulo is a mask of the low index bits.
  always_comb begin
    case (tile[CTG_TILE_ROW_LSB +: 2])
      2'b00: tile_row = 2'b00;
      2'b01: tile_row = {1'b0, pix_row_i[0]};
      default: tile_row = pix_row_i[1:0];
    endcase
    case (tile[CTG_TILE_COL_LSB +: 2])
      2'b00: tile_col = 2'b00;
      2'b01: tile_col = {1'b0, pix_col_i[0]};
      default: tile_col = pix_col_i[1:0];
    endcase
    cur_row_def = row_def[tile_row];
    selector = cur_row_def[tile_col*CTG_SEL_W +: CTG_SEL_W];
    sel.code = gain_live[selector];
    sel.x100 = 8'(CTG_GAIN_BASE_C + CTG_GAIN_STEP_C * int'(sel.code));
  end

  // ==========================================================================
  // Output FIFO: back-pressure reaches the pixel source through pix_ready_o.
  logic [13:0] fifo_out;

  ctg_fifo #(
    .WIDTH(14),
    .DEPTH(CTG_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .in_data_i(sel),
    .out_valid_o(gain_valid_o),
    .out_ready_i(gain_ready_i),
    .out_data_o(fifo_out)
  );

  assign gain_code_o = fifo_out[13:8];
  assign gain_x100_o = fifo_out[7:0];

  factor_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    gain_valid_o |-> gain_x100_o == 8'(88 + 6 * int'(gain_code_o))) else $error("Gain factor mismatch");
  one_col_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tile[3:2] == 2'b00 |-> tile_col == 2'b00) else $error("Column leaks in one-column tile");
  two_row_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tile[1:0] == 2'b01 |-> tile_row == {1'b0, pix_row_i[0]}) else $error("Row modulo wrong");
  sel_pick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sel.code == gain_live[row_def[tile_row][tile_col*2 +: 2]]) else $error("Wrong gain picked");
  stall_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    gain_valid_o && !gain_ready_i |=> gain_valid_o && $stable(gain_code_o)) else $error("Output dropped");
endmodule
`default_nettype wire

// ==== rtl/ctg_pkg.sv ====
// Package of register map, field layout and reset values for the colour tile gain selector.
package ctg_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] CTG_OFS_GAIN1 = 8'h00;
  localparam logic [7:0] CTG_OFS_GAIN2 = 8'h01;
  localparam logic [7:0] CTG_OFS_GAIN3 = 8'h02;
  localparam logic [7:0] CTG_OFS_GAIN4 = 8'h03;
  localparam logic [7:0] CTG_OFS_TILE = 8'h05;
  localparam logic [7:0] CTG_OFS_ROW1 = 8'h06;
  localparam logic [7:0] CTG_OFS_ROW4 = 8'h09;

  // ==========================================================================
  // Field layout
  localparam int CTG_GAIN_W = 6;
  localparam int CTG_TILE_COL_LSB = 2;
  localparam int CTG_TILE_ROW_LSB = 0;
  localparam int CTG_SEL_W = 2;
  localparam int CTG_DATA_W = 8;
  localparam int CTG_IDX_W = 10;
  localparam int CTG_FIFO_DEPTH = 8;

  // ==========================================================================
  // Reset values
  localparam logic [5:0] CTG_GAIN_RST = 6'h02;
  localparam logic [3:0] CTG_TILE_RST = 4'h5;
  localparam logic [7:0] CTG_ROW1_RST = 8'h44;
  localparam logic [7:0] CTG_ROW2_RST = 8'hee;
  localparam logic [7:0] CTG_ROW34_RST = 8'h00;

  // Gain factor in hundredths: base plus step per code unit.
  localparam int CTG_GAIN_BASE_C = 88;
  localparam int CTG_GAIN_STEP_C = 6;

endpackage

// ==== rtl/ctg_fifo.sv ====
// Small flip-flop FIFO carrying selected gain codes with their gain factors in hundredths.
`timescale 1ns/10ps
`default_nettype none
module ctg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ctg_fifo_s;

  ctg_fifo_s st_r;
  ctg_fifo_s st_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o = st_r.mem[st_r.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data_i;
      st_nxt.wr = AW'(st_r.wr + 1'b1);
    end
    if (pop) begin
      st_nxt.rd = AW'(st_r.rd + 1'b1);
    end
    st_nxt.cnt = (AW+1)'(st_r.cnt + push - pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_r.cnt <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule
`default_nettype wire

// ==== rtl/ctg_regs.sv ====
// Register file holding gain codes, tile size and row definitions.
`timescale 1ns/10ps
`default_nettype none
module ctg_regs
  import ctg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Frame boundary
  input wire logic frame_start_i,
  // Configuration out
  output logic [3:0][5:0] gain_live_o,
  output logic [3:0] tile_o,
  output logic [3:0][7:0] row_def_o
);
  typedef struct packed {
    logic [3:0][5:0] gain_pend;
    logic [3:0][5:0] gain_live;
    logic [3:0] tile;
    logic [3:0][7:0] row_def;
    logic [7:0] rdata;
  } ctg_regs_s;

  ctg_regs_s st_r;
  ctg_regs_s st_nxt;

  // The reset image is a constant so the asynchronous reset branch loads no logic-driven value.
  localparam ctg_regs_s ST_RST = '{
    gain_pend: {4{CTG_GAIN_RST}},
    gain_live: {4{CTG_GAIN_RST}},
    tile: CTG_TILE_RST,
    row_def: {CTG_ROW34_RST, CTG_ROW34_RST, CTG_ROW2_RST, CTG_ROW1_RST},
    rdata: 8'h00
  };

  always_comb begin
    st_nxt = st_r;
    // Gain codes are shadowed so a frame never sees mixed white balance.
    if (frame_start_i) begin
      st_nxt.gain_live = st_r.gain_pend;
    end
    if (wr_en_i) begin
      if (addr_i >= CTG_OFS_GAIN1 && addr_i <= CTG_OFS_GAIN4) begin
        st_nxt.gain_pend[addr_i[1:0]] = wdata_i[5:0];
      end else if (addr_i == CTG_OFS_TILE) begin
        st_nxt.tile = wdata_i[3:0];
      end else if (addr_i >= CTG_OFS_ROW1 && addr_i <= CTG_OFS_ROW4) begin
        st_nxt.row_def[2'(addr_i - CTG_OFS_ROW1)] = wdata_i;
      end
    end
    if (addr_i >= CTG_OFS_GAIN1 && addr_i <= CTG_OFS_GAIN4) begin
      st_nxt.rdata = {2'b00, st_r.gain_pend[addr_i[1:0]]};
    end else if (addr_i == CTG_OFS_TILE) begin
      st_nxt.rdata = {4'h0, st_r.tile};
    end else if (addr_i >= CTG_OFS_ROW1 && addr_i <= CTG_OFS_ROW4) begin
      st_nxt.rdata = st_r.row_def[2'(addr_i - CTG_OFS_ROW1)];
    end else begin
      st_nxt.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign gain_live_o = st_r.gain_live;
  assign tile_o = st_r.tile;
  assign row_def_o = st_r.row_def;

  shadow_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(frame_start_i) |-> gain_live_o == $past(gain_live_o)) else $error("Live gain changed mid frame");
  shadow_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    frame_start_i |=> gain_live_o == $past(st_r.gain_pend)) else $error("Shadow not loaded at frame");
  tile_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == CTG_OFS_TILE |=> tile_o == $past(wdata_i[3:0])) else $error("Tile write lost");
endmodule
`default_nettype wire

// ==== sim/ctg_host.sv ====
// Host model that sets white balance gains over the byte register port.
`timescale 1ns/10ps
`default_nettype none
module ctg_host (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // ==========================================================================
  // Bus cycles
  // Gains change as lighting does; tile and rows move only in odd-pattern tests.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask

  // Read data is registered, so it is taken one cycle after the address.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ==== sim/color_tile_gain_selector_tb_top.sv ====
// Self-checking testbench of the colour tile gain selector.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module color_tile_gain_selector_tb_top;
  import ctg_pkg::*;
  logic clk_i = 0, rst_n_i = 0, frame_start_i = 0, pix_valid_i = 0, gain_ready_i = 1;
  logic reg_wr_i, pix_ready_o, gain_valid_o, stall = 0, hold = 1;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, gain_x100_o, rv;
  logic [CTG_IDX_W-1:0] pix_row_i = 0, pix_col_i = 0;
  logic [CTG_GAIN_W-1:0] gain_code_o;
  logic [5:0] pend [4], live [4];
  logic [5:0] exp_q [$];
  logic [3:0] tile;
  logic [7:0] rdef [4];
  int failures = 0, n_tests = 0;

  always #50 clk_i = ~clk_i;

  ctg_top i_ctg_top (.clk_i, .rst_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .frame_start_i, .pix_valid_i, .pix_ready_o, .pix_row_i, .pix_col_i, .gain_valid_o,
    .gain_ready_i, .gain_code_o, .gain_x100_o);
  ctg_host i_ctg_host (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

  // ==========================================================================
  // Reference model
  function automatic logic [5:0] expc(logic [9:0] r, logic [9:0] c);
    int nr, nc;
    nr = tile[1] ? 4 : (tile[0] ? 2 : 1);
    nc = tile[3] ? 4 : (tile[2] ? 2 : 1);
    return live[rdef[r % nr][2 * (c % nc) +: 2]];
  endfunction

  function automatic logic [7:0] rexp(logic [7:0] a);
    if (a < 8'h04) return {2'b00, pend[a[1:0]]};
    if (a == 8'h05) return {4'h0, tile};
    if (a >= 8'h06 && a <= 8'h09) return rdef[a - 8'h06];
    return 8'h00;
  endfunction

  // ==========================================================================
  // Tasks
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    pix_valid_i = 1'b0;
    i_ctg_host.wr(a, d);
    if (a < 8'h04) pend[a[1:0]] = d[5:0];
    if (a == 8'h05) tile = d[3:0];
    if (a >= 8'h06 && a <= 8'h09) rdef[a - 8'h06] = d;
  endtask

  task automatic rchk(input logic [7:0] a);
    i_ctg_host.rd(a, rv);
    `CHK(rv, rexp(a))
  endtask

  task automatic frame();
    pix_valid_i = 1'b0;
    @(negedge clk_i);
    frame_start_i = 1'b1;
    @(negedge clk_i);
    frame_start_i = 1'b0;
    live = pend;
  endtask

  // Entered at a falling edge; valid stays up so pixels can go back to back.
  task automatic pix(input logic [9:0] r, input logic [9:0] c);
    int k = 0;
    pix_valid_i = 1'b1;
    pix_row_i = r;
    pix_col_i = c;
    while (pix_ready_o !== 1'b1 && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    `CHK(pix_ready_o, 1'b1)
    exp_q.push_back(expc(r, c));
    @(negedge clk_i);
  endtask

  task automatic drain();
    int k = 0;
    pix_valid_i = 1'b0;
    while (exp_q.size() != 0 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    `CHK(exp_q.size(), 0)
  endtask

  task automatic close_out();
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Output monitor
  // Drain side is driven and watched at the falling edge, where the FIFO outputs have settled.
  always @(negedge clk_i) begin
    gain_ready_i = stall ? 1'($urandom) : hold;
    if (rst_n_i && gain_valid_o === 1'b1 && gain_ready_i === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) begin
        `CHK(gain_code_o, exp_q[0])
        `CHK(gain_x100_o, 8'(88 + 6 * exp_q[0]))
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    #2000000;
    failures++;
    close_out();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(82));
    pend = '{4{6'h02}};
    live = pend;
    tile = 4'h5;
    rdef = '{8'h44, 8'hee, 8'h00, 8'h00};
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int a = 0; a < 12; a++) rchk(8'(a));
    // Upper bits set on purpose: they must read back as zero.
    for (int a = 0; a < 4; a++) w(8'(a), 8'(8'hd0 + a));
    for (int a = 0; a < 4; a++) rchk(8'(a));
    for (int p = 0; p < 8; p++) pix(10'(p / 4), 10'(p));
    drain();
    frame();
    for (int p = 0; p < 8; p++) pix(10'(p / 4), 10'(p));
    drain();
    hold = 1'b0;
    for (int p = 0; p < 8; p++) pix(10'(p), 10'(p + 1));
    `CHK(pix_ready_o, 1'b0)
    hold = 1'b1;
    drain();
    stall = 1'b1;
    repeat (60) begin
      w(8'($urandom_range(9, 0)), 8'($urandom));
      if ($urandom % 4 == 0) frame();
      repeat (6) pix(10'($urandom), 10'($urandom));
    end
    stall = 1'b0;
    drain();
    for (int a = 0; a < 12; a++) rchk(8'(a));
    close_out();
  end
endmodule
`default_nettype wire
